// File: include/vimc_defines.vh
// Constants for the virtual interrupt map command executor.
`ifndef VIMC_DEFINES_VH
`define VIMC_DEFINES_VH

// Command opcodes in doubleword 0 bits [7:0]; the first two values are arbitrary.
`define VIMC_OP_INVALL      8'h01
`define VIMC_OP_MAPI        8'h02
`define VIMC_OP_MAPP        8'h29
`define VIMC_OP_W           8

// Packet layout: four doublewords, 32 bytes.
`define VIMC_PKT_BYTES      32
`define VIMC_WORD_COUNT     4
`define VIMC_WORD_IDX_W     2

// Field widths of this implementation.
`define VIMC_DEV_W          4
`define VIMC_EVT_W          32
`define VIMC_VC_W           3
`define VIMC_VC_COUNT       8
`define VIMC_DEV_COUNT      16
`define VIMC_ITE_COUNT      64
`define VIMC_ITE_IDX_W      6
`define VIMC_EVT_IDX_W      2
`define VIMC_SIZE_W         5
`define VIMC_RD_W           32
`define VIMC_PTA_W          36
`define VIMC_PT_ADDR_W      52
`define VIMC_PT_ZERO_W      16

// Interrupt number limits.
`define VIMC_MSG_MIN        32'h00002000
`define VIMC_SPURIOUS       32'h000003ff
`define VIMC_MSG_SPAN       32'h00001000
`define VIMC_SIZE_FLOOR     5'h0e

// Field positions within doublewords.
`define VIMC_DEV_LSB        32
`define VIMC_EVT_LSB        0
`define VIMC_VC_LSB         32
`define VIMC_DB_LSB         32
`define VIMC_RD_LSB         16
`define VIMC_V_BIT          63
`define VIMC_PTA_LSB        16
`define VIMC_SIZE_LSB       0

// Error cause codes.
`define VIMC_ERR_W          4
`define VIMC_ERR_NONE       4'h0
`define VIMC_ERR_VC_OOR     4'h1
`define VIMC_ERR_VC_INVALID 4'h2
`define VIMC_ERR_DEV_OOR    4'h3
`define VIMC_ERR_DEV_UNMAP  4'h4
`define VIMC_ERR_ID_OOR     4'h5
`define VIMC_ERR_DB_OOR     4'h6
`define VIMC_ERR_SIZE_OOR   4'h7
`define VIMC_ERR_BAD_OP     4'h8

// Reset values of the per-core tables.
`define VIMC_VC_INV_RST     1'b0

`endif

// File: hw/vimc_cmd_exec.v
// Executes core-invalidate, identity-map and core-map commands from a command queue.
`timescale 1ns/1ns
`include "vimc_defines.vh"

module vimc_cmd_exec
(
    // Clock and reset
    input  wire                          clk,
    input  wire                          rst,
    // Command doubleword stream from the queue
    input  wire                          cmdValid,
    input  wire [63:0]                   cmdWord,
    input  wire [`VIMC_WORD_IDX_W-1:0]   cmdIndex,
    output wire                          cmdReady,
    output reg                           readAdvance,
    // Capability and configuration
    input  wire                          system_error_report_support,
    input  wire [`VIMC_SIZE_W-1:0]       identifier_width_field,
    input  wire                          extendedVersion,
    // Device table programming from the device table map command
    input  wire                          devMapWrite,
    input  wire [`VIMC_DEV_W-1:0]        devMapNumber,
    input  wire                          devMapValid,
    input  wire [`VIMC_EVT_IDX_W-1:0]    devMapSize,
    // Doorbell request for an unscheduled core
    input  wire                          doorbellQuery,
    input  wire [`VIMC_ITE_IDX_W-1:0]    doorbellEntry,
    input  wire                          coreScheduled,
    output reg                           doorbellFire,
    output reg  [`VIMC_EVT_W-1:0]        doorbellNumber,
    // Cache invalidation and unit-side config handshake
    output reg                           invalidateReq,
    output reg  [`VIMC_VC_W-1:0]         invalidateCore,
    input  wire                          invalidateDone,
    // Error report
    output reg                           systemError,
    output reg  [`VIMC_ERR_W-1:0]        errorCause,
    // Status
    output reg  [`VIMC_VC_COUNT-1:0]     coreValidMap,
    output reg  [`VIMC_PT_ADDR_W-1:0]    lastPendingBase,
    output reg  [`VIMC_SIZE_W-1:0]       lastPendingSize,
    output reg  [`VIMC_RD_W-1:0]         lastTarget
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer states; only an error-free invalidate, or core map in the extended version, enters WAIT and stays until the far side confirms its effects.
localparam [1:0] ST_COLLECT = 2'h0;
localparam [1:0] ST_EXEC    = 2'h1;
localparam [1:0] ST_WAIT    = 2'h2;
localparam [1:0] ST_DONE    = 2'h3;

// Range check: number must lie below count.
function inRange;
    input [31:0] value;
    input [31:0] count;
    begin
        inRange = (value < count);
    end
endfunction

// Message interrupt range for this implementation, 0x2000 and above, with no upper bound.
function msgValid;
    input [31:0] value;
    begin
        msgValid = (value >= `VIMC_MSG_MIN);
    end
endfunction

reg [1:0]                   state_reg;
reg [1:0]                   state_next;
reg [63:0]                  pkt_reg [0:`VIMC_WORD_COUNT-1];
reg [`VIMC_WORD_COUNT-1:0]  have_reg;

// Core table.
reg [`VIMC_RD_W-1:0]        coreTarget [0:`VIMC_VC_COUNT-1];
reg [`VIMC_PT_ADDR_W-1:0]   corePtBase [0:`VIMC_VC_COUNT-1];
reg [`VIMC_SIZE_W-1:0]      corePtSize [0:`VIMC_VC_COUNT-1];
// Device table.
reg [`VIMC_DEV_COUNT-1:0]   devValid;
reg [`VIMC_EVT_IDX_W-1:0]   devSize [0:`VIMC_DEV_COUNT-1];
// Translation entries: one per device and event slot.
reg                         iteValid [0:`VIMC_ITE_COUNT-1];
reg                         iteVirtual [0:`VIMC_ITE_COUNT-1];
reg [`VIMC_EVT_W-1:0]       iteOutput [0:`VIMC_ITE_COUNT-1];
reg [`VIMC_EVT_W-1:0]       iteDoorbell [0:`VIMC_ITE_COUNT-1];
reg [`VIMC_VC_W-1:0]        iteCore [0:`VIMC_ITE_COUNT-1];

////////////////////////////////////////////////////////////////////////////////
// Field extraction by doubleword position.
wire [63:0]                 dw0 = pkt_reg[0];
wire [63:0]                 dw1 = pkt_reg[1];
wire [63:0]                 dw2 = pkt_reg[2];
wire [63:0]                 dw3 = pkt_reg[3];
wire [`VIMC_OP_W-1:0]       opcode = dw0[`VIMC_OP_W-1:0];
wire [31:0]                 devNum = dw0[`VIMC_DEV_LSB+31:`VIMC_DEV_LSB];
wire [31:0]                 evtNum = dw1[`VIMC_EVT_LSB+31:`VIMC_EVT_LSB];
wire [31:0]                 vcNum = dw1[`VIMC_VC_LSB+31:`VIMC_VC_LSB];
wire [31:0]                 dbNum = dw2[`VIMC_DB_LSB+31:`VIMC_DB_LSB];
wire                        vFlag = dw2[`VIMC_V_BIT];
wire [`VIMC_RD_W-1:0]       rdBase = dw2[`VIMC_RD_LSB+`VIMC_RD_W-1:`VIMC_RD_LSB];
wire [`VIMC_PTA_W-1:0]      ptAddr = dw3[`VIMC_PTA_LSB+`VIMC_PTA_W-1:`VIMC_PTA_LSB];
wire [`VIMC_SIZE_W-1:0]     ptSize = dw3[`VIMC_SIZE_LSB+`VIMC_SIZE_W-1:`VIMC_SIZE_LSB];
wire [`VIMC_VC_W-1:0]       vcIdx = vcNum[`VIMC_VC_W-1:0];
wire [`VIMC_DEV_W-1:0]      devIdx = devNum[`VIMC_DEV_W-1:0];
// Event slots count up from the message base, so the base event takes slot zero.
wire [31:0]                 evtSlot = evtNum - `VIMC_MSG_MIN;
wire [`VIMC_EVT_IDX_W-1:0]  evtIdx = evtSlot[`VIMC_EVT_IDX_W-1:0];
wire [`VIMC_ITE_IDX_W-1:0]  iteIdx = {devIdx, evtIdx};
wire [`VIMC_PT_ADDR_W-1:0]  ptBaseFull = {ptAddr, {`VIMC_PT_ZERO_W{1'b0}}};
// Small sizes are raised to the least in the extended version.
wire [`VIMC_SIZE_W-1:0]     sizeFloor = `VIMC_SIZE_FLOOR;
wire [`VIMC_SIZE_W-1:0]     ptSizeUsed = (extendedVersion && ptSize < sizeFloor)
                                         ? sizeFloor : ptSize;
// Doorbell numbers must be the spurious number or lie in the implemented message range above the base.
wire [31:0]                 msgCount = `VIMC_MSG_MIN + `VIMC_MSG_SPAN;
wire                        vcOk = inRange(vcNum, `VIMC_VC_COUNT);
wire                        devOk = inRange(devNum, `VIMC_DEV_COUNT);
wire                        evtOk = devOk && (evtSlot[31:`VIMC_EVT_IDX_W] == 30'h0)
                                    && (evtIdx <= devSize[devIdx]);
wire                        dbOk = (dbNum == `VIMC_SPURIOUS)
                                   || (msgValid(dbNum) && dbNum < msgCount);
wire                        pktFull = &have_reg;

////////////////////////////////////////////////////////////////////////////////
// Error decision for the held command.
reg [`VIMC_ERR_W-1:0]       errCode;
always @*
begin
    errCode = `VIMC_ERR_NONE;
    case (opcode)
        `VIMC_OP_INVALL:
        begin
            if (!vcOk)
                errCode = `VIMC_ERR_VC_OOR;
            else if (!coreValidMap[vcIdx])
                errCode = `VIMC_ERR_VC_INVALID;
        end
        `VIMC_OP_MAPI:
        begin
            if (!devOk)
                errCode = `VIMC_ERR_DEV_OOR;
            else if (!vcOk)
                errCode = `VIMC_ERR_VC_OOR;
            else if (!devValid[devIdx])
                errCode = `VIMC_ERR_DEV_UNMAP;
            else if (!evtOk || !msgValid(evtNum))
                errCode = `VIMC_ERR_ID_OOR;
            else if (!dbOk)
                errCode = `VIMC_ERR_DB_OOR;
        end
        `VIMC_OP_MAPP:
        begin
            if (!vcOk)
                errCode = `VIMC_ERR_VC_OOR;
            else if (!extendedVersion && ptSize > identifier_width_field)
                errCode = `VIMC_ERR_SIZE_OOR;
        end
        default:
            errCode = `VIMC_ERR_BAD_OP;
    endcase
end

// An event below the message base wraps to a huge slot, so both checks give the
// same cause code; the slot check alone keeps the table index inside the device.

////////////////////////////////////////////////////////////////////////////////
// Sequencer. A packet is taken only while collecting, so commands run in order.
assign cmdReady = (state_reg == ST_COLLECT);

always @*
begin
    state_next = state_reg;
    case (state_reg)
        ST_COLLECT:
            if (pktFull)
                state_next = ST_EXEC;
        ST_EXEC:
            if (errCode == `VIMC_ERR_NONE && (opcode == `VIMC_OP_INVALL
                || (opcode == `VIMC_OP_MAPP && extendedVersion)))
                state_next = ST_WAIT;
            else
                state_next = ST_DONE;
        ST_WAIT:
            if (invalidateDone)
                state_next = ST_DONE;
        ST_DONE:
            state_next = ST_COLLECT;
        default:
            state_next = ST_COLLECT;
    endcase
end

integer i;
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        state_reg       <= ST_COLLECT;
        have_reg        <= {`VIMC_WORD_COUNT{1'b0}};
        readAdvance     <= 1'b0;
        invalidateReq   <= 1'b0;
        invalidateCore  <= {`VIMC_VC_W{1'b0}};
        systemError     <= 1'b0;
        errorCause      <= `VIMC_ERR_NONE;
        coreValidMap    <= {`VIMC_VC_COUNT{`VIMC_VC_INV_RST}};
        devValid        <= {`VIMC_DEV_COUNT{1'b0}};
        lastPendingBase <= {`VIMC_PT_ADDR_W{1'b0}};
        lastPendingSize <= {`VIMC_SIZE_W{1'b0}};
        lastTarget      <= {`VIMC_RD_W{1'b0}};
        for (i = 0; i < `VIMC_WORD_COUNT; i = i + 1)
            pkt_reg[i] <= 64'h0;
        for (i = 0; i < `VIMC_VC_COUNT; i = i + 1)
        begin
            coreTarget[i] <= {`VIMC_RD_W{1'b0}};
            corePtBase[i] <= {`VIMC_PT_ADDR_W{1'b0}};
            corePtSize[i] <= {`VIMC_SIZE_W{1'b0}};
        end
        for (i = 0; i < `VIMC_DEV_COUNT; i = i + 1)
            devSize[i] <= {`VIMC_EVT_IDX_W{1'b0}};
        for (i = 0; i < `VIMC_ITE_COUNT; i = i + 1)
        begin
            iteValid[i]    <= 1'b0;
            iteVirtual[i]  <= 1'b0;
            iteOutput[i]   <= {`VIMC_EVT_W{1'b0}};
            iteDoorbell[i] <= {`VIMC_EVT_W{1'b0}};
            iteCore[i]     <= {`VIMC_VC_W{1'b0}};
        end
    end
    else
    begin
        state_reg   <= state_next;
        readAdvance <= 1'b0;
        systemError <= 1'b0;
        // The device table is filled by the device table map path beside this block.
        if (devMapWrite)
        begin
            devValid[devMapNumber] <= devMapValid;
            devSize[devMapNumber]  <= devMapSize;
        end
        case (state_reg)
            ST_COLLECT:
                if (cmdValid)
                begin
                    pkt_reg[cmdIndex]  <= cmdWord;
                    have_reg[cmdIndex] <= 1'b1;
                end
            ST_EXEC:
            begin
                have_reg <= {`VIMC_WORD_COUNT{1'b0}};
                if (errCode != `VIMC_ERR_NONE)
                begin
                    systemError <= system_error_report_support;
                    errorCause  <= errCode;
                end
                else if (opcode == `VIMC_OP_INVALL)
                begin
                    invalidateReq  <= 1'b1;
                    invalidateCore <= vcIdx;
                end
                else if (opcode == `VIMC_OP_MAPI)
                begin
                    iteValid[iteIdx]    <= 1'b1;
                    iteVirtual[iteIdx]  <= 1'b1;
                    iteOutput[iteIdx]   <= evtNum;
                    iteDoorbell[iteIdx] <= dbNum;
                    iteCore[iteIdx]     <= vcIdx;
                end
                else
                begin
                    coreValidMap[vcIdx] <= vFlag;
                    coreTarget[vcIdx]   <= rdBase;
                    corePtBase[vcIdx]   <= ptBaseFull;
                    corePtSize[vcIdx]   <= ptSizeUsed;
                    lastTarget          <= rdBase;
                    lastPendingBase     <= ptBaseFull;
                    lastPendingSize     <= ptSizeUsed;
                    if (extendedVersion)
                    begin
                        invalidateReq  <= 1'b1;
                        invalidateCore <= vcIdx;
                    end
                end
            end
            ST_WAIT:
                if (invalidateDone)
                    invalidateReq <= 1'b0;
            ST_DONE:
                readAdvance <= 1'b1;
            default:
                have_reg <= {`VIMC_WORD_COUNT{1'b0}};
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Doorbell path. Only a virtual entry whose core is not scheduled and whose
// doorbell is not the spurious number rings.
wire                        doorbellHit = doorbellQuery && iteValid[doorbellEntry]
                                          && iteVirtual[doorbellEntry];
wire                        doorbellReal = (iteDoorbell[doorbellEntry] != `VIMC_SPURIOUS);
wire                        doorbellRing = doorbellHit && !coreScheduled && doorbellReal;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        doorbellFire   <= 1'b0;
        doorbellNumber <= {`VIMC_EVT_W{1'b0}};
    end
    else
    begin
        doorbellFire <= doorbellRing;
        // The number keeps its last value between doorbells.
        if (doorbellRing)
            doorbellNumber <= iteDoorbell[doorbellEntry];
    end
end

endmodule // vimc_cmd_exec

// File: dv/vimc_cmd_exec_properties.sv
// Port assertions for the virtual interrupt map command executor.
`timescale 1ns/1ns
`include "vimc_defines.vh"

module vimc_cmd_exec_chk
(
    // Clock and reset
    input wire                       clk,
    input wire                       rst,
    // Queue side
    input wire                       cmdReady,
    input wire                       readAdvance,
    // Configuration
    input wire                       system_error_report_support,
    input wire                       extendedVersion,
    // Doorbell
    input wire                       doorbellQuery,
    input wire                       coreScheduled,
    input wire                       doorbellFire,
    input wire [`VIMC_EVT_W-1:0]     doorbellNumber,
    // Invalidate handshake
    input wire                       invalidateReq,
    input wire [`VIMC_VC_W-1:0]      invalidateCore,
    input wire                       invalidateDone,
    // Errors and status
    input wire                       systemError,
    input wire [`VIMC_ERR_W-1:0]     errorCause,
    input wire [`VIMC_PT_ADDR_W-1:0] lastPendingBase,
    input wire [`VIMC_SIZE_W-1:0]    lastPendingSize
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_adv_pulse: assert property (readAdvance |=> !readAdvance)
        else $error("readAdvance held longer than one cycle");
    chk_adv_after_exec: assert property ($rose(readAdvance) |-> !$past(cmdReady))
        else $error("readAdvance without a command in execution");
    chk_err_pulse: assert property (systemError |=> !systemError)
        else $error("systemError held longer than one cycle");
    chk_err_gated: assert property (systemError |-> $past(system_error_report_support)
        && errorCause != 4'h0)
        else $error("systemError without support flag or cause");
    chk_err_advance: assert property (systemError |-> ##[1:3] readAdvance)
        else $error("failed command not consumed");
    chk_inv_hold: assert property (invalidateReq && !invalidateDone
        |=> invalidateReq && $stable(invalidateCore))
        else $error("invalidate request dropped or core changed early");
    chk_inv_order: assert property (invalidateReq |-> !readAdvance)
        else $error("pointer advanced with invalidation outstanding");
    chk_inv_finish: assert property (invalidateReq && invalidateDone
        |-> ##[1:3] readAdvance)
        else $error("no advance after invalidation finished");
    chk_door_quiet: assert property (doorbellQuery && coreScheduled |=> !doorbellFire)
        else $error("doorbell fired for a scheduled core");
    chk_door_cause: assert property (doorbellFire |-> $past(doorbellQuery)
        && !$past(coreScheduled) && doorbellNumber != `VIMC_SPURIOUS)
        else $error("doorbell fired without cause or as spurious");
    chk_base_align: assert property (lastPendingBase[15:0] == 16'h0)
        else $error("pending table base not 64KB aligned");
    chk_ext_size: assert property (extendedVersion && $changed(lastPendingSize)
        |-> lastPendingSize >= 5'h0e)
        else $error("extended size below minimum");
endmodule // vimc_cmd_exec_chk

bind vimc_cmd_exec vimc_cmd_exec_chk vimc_cmd_exec_chk_i (
    .clk(clk), .rst(rst), .cmdReady(cmdReady), .readAdvance(readAdvance),
    .system_error_report_support(system_error_report_support),
    .extendedVersion(extendedVersion), .doorbellQuery(doorbellQuery),
    .coreScheduled(coreScheduled), .doorbellFire(doorbellFire),
    .doorbellNumber(doorbellNumber), .invalidateReq(invalidateReq),
    .invalidateCore(invalidateCore), .invalidateDone(invalidateDone),
    .systemError(systemError), .errorCause(errorCause),
    .lastPendingBase(lastPendingBase), .lastPendingSize(lastPendingSize));

// File: dv/vimc_sw_queue.sv
// Software-side model: feeds command packets and answers invalidations.
`timescale 1ns/1ns

module vimc_sw_queue
(
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Packet to send and answer delay
    input  wire         start,
    input  wire [255:0] pkt,
    input  wire [3:0]   doneDelay,
    // Executor side
    input  wire         cmdReady,
    input  wire         invalidateReq,
    output logic        cmdValid,
    output logic [63:0] cmdWord,
    output logic [1:0]  cmdIndex,
    output logic        invalidateDone
);
    logic       busy;
    logic [3:0] waitCnt;

    // Words are held until taken; an idle word bus shows the inverse of the last word.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmdValid <= 1'b0;
            cmdWord <= 64'h0;
            cmdIndex <= 2'h0;
            busy <= 1'b0;
            waitCnt <= 4'h0;
            invalidateDone <= 1'b0;
        end
        else
        begin
            invalidateDone <= invalidateReq && waitCnt == doneDelay;
            waitCnt <= invalidateReq ? waitCnt + 4'h1 : 4'h0;
            if (start && !busy) // One packet at a time; no core move is ever queued.
            begin
                busy <= 1'b1;
                cmdValid <= 1'b1;
                cmdIndex <= 2'h0;
                cmdWord <= pkt[63:0];
            end
            else if (cmdValid && cmdReady)
            begin
                if (cmdIndex == 2'h3)
                begin
                    busy <= 1'b0;
                    cmdValid <= 1'b0;
                    cmdWord <= ~cmdWord;
                end
                else
                begin
                    cmdIndex <= cmdIndex + 2'h1;
                    cmdWord <= pkt[{cmdIndex + 2'h1, 6'h0} +: 64];
                end
            end
        end
    end
endmodule // vimc_sw_queue

// File: dv/virtual_interrupt_map_commands_tb.sv
// Self-checking bench for the virtual interrupt map command executor.
`timescale 1ns/1ns
`include "vimc_defines.vh"

module virtual_interrupt_map_commands_tb;
    localparam logic [7:0] INV = `VIMC_OP_INVALL;
    localparam logic [7:0] MPI = `VIMC_OP_MAPI;
    localparam logic [7:0] MPP = `VIMC_OP_MAPP;
    localparam logic [63:0] NO_BELL = {32'h3ff, 32'h0};
    logic         clk, rst, start, cmdValid, cmdReady, readAdvance, errSupport, extVer;
    logic         devMapWrite, devMapValid, doorbellQuery, coreScheduled, doorbellFire;
    logic         invalidateReq, invalidateDone, systemError, sawErr;
    logic [255:0] pkt;
    logic [63:0]  cmdWord;
    logic [51:0]  lastPendingBase;
    logic [31:0]  doorbellNumber, lastTarget;
    logic [7:0]   coreValidMap;
    logic [5:0]   doorbellEntry;
    logic [4:0]   idWidth, lastPendingSize;
    logic [3:0]   doneDelay, devMapNumber, errorCause;
    logic [2:0]   invalidateCore, seenCore;
    logic [1:0]   cmdIndex, devMapSize;
    int           n_errors, check_count, cycles, k;

    vimc_cmd_exec vimc_cmd_exec_i (.clk(clk), .rst(rst), .cmdValid(cmdValid),
        .cmdWord(cmdWord), .cmdIndex(cmdIndex), .cmdReady(cmdReady),
        .readAdvance(readAdvance), .system_error_report_support(errSupport),
        .identifier_width_field(idWidth), .extendedVersion(extVer),
        .devMapWrite(devMapWrite), .devMapNumber(devMapNumber), .devMapValid(devMapValid),
        .devMapSize(devMapSize), .doorbellQuery(doorbellQuery),
        .doorbellEntry(doorbellEntry), .coreScheduled(coreScheduled),
        .doorbellFire(doorbellFire), .doorbellNumber(doorbellNumber),
        .invalidateReq(invalidateReq), .invalidateCore(invalidateCore),
        .invalidateDone(invalidateDone), .systemError(systemError),
        .errorCause(errorCause), .coreValidMap(coreValidMap),
        .lastPendingBase(lastPendingBase), .lastPendingSize(lastPendingSize),
        .lastTarget(lastTarget));
    vimc_sw_queue vimc_sw_queue_i (.clk(clk), .rst(rst), .start(start), .pkt(pkt),
        .doneDelay(doneDelay), .cmdReady(cmdReady), .invalidateReq(invalidateReq),
        .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdIndex(cmdIndex),
        .invalidateDone(invalidateDone));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Sends one packet and waits for the queue pointer to move.
    task automatic run_cmd(input logic [7:0] op, input logic [31:0] hi0,
        input logic [63:0] w1, input logic [63:0] w2, input logic [63:0] w3,
        input logic [3:0] expErr);
        @(posedge clk);
        pkt <= {w3, w2, w1, hi0, 24'h0, op};
        start <= 1'b1;
        sawErr <= 1'b0;
        @(posedge clk);
        start <= 1'b0;
        #1;
        for (k = 0; k < 80 && readAdvance !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        check("readAdvance", 64'h1, readAdvance);
        check("systemError", expErr != 4'h0 && errSupport, sawErr);
        if (errSupport && expErr != 4'h0)
            check("errorCause", expErr, errorCause);
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
        if (systemError === 1'b1)
            sawErr <= 1'b1;
        if (invalidateReq === 1'b1)
            seenCore <= invalidateCore;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, errSupport} = 2'h3;
        {start, extVer, devMapWrite, devMapValid, doorbellQuery, coreScheduled} = 6'h0;
        {sawErr, seenCore, pkt, doneDelay, devMapNumber, devMapSize, doorbellEntry} = 0;
        idWidth = 5'h0f;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        run_cmd(INV, 32'h0, {32'h8, 32'h0}, 64'h0, 64'h0, `VIMC_ERR_VC_OOR);
        run_cmd(INV, 32'h0, {32'h2, 32'h0}, 64'h0, 64'h0, `VIMC_ERR_VC_INVALID);
        run_cmd(MPP, 32'h0, {32'h9, 32'h0}, 64'h0, 64'h0, `VIMC_ERR_VC_OOR);
        run_cmd(MPP, 32'h0, {32'h2, 32'h0}, {1'b1, 63'h0}, 64'h10, `VIMC_ERR_SIZE_OOR);
        run_cmd(MPP, 32'h0, {32'h2, 32'h0}, {1'b1, 15'h0, 32'h12340, 16'h0},
            {12'h0, 36'h1_2345_6789, 16'h000f}, 4'h0);
        check("coreValidMap", 8'h04, coreValidMap);
        check("lastPendingBase", 52'h1_2345_6789_0000, lastPendingBase);
        check("lastPendingSize", 5'h0f, lastPendingSize);
        check("lastTarget", 32'h12340, lastTarget);
        // Prompt and slow answers from the far side.
        for (int d = 0; d < 8; d += 6)
        begin
            doneDelay <= d[3:0];
            run_cmd(INV, 32'h0, {32'h2, 32'h0}, 64'h0, 64'h0, 4'h0);
            check("invalidateCore", 3'h2, seenCore);
        end
        run_cmd(MPI, 32'h14, {32'h2, 32'h2000}, NO_BELL, 64'h0, `VIMC_ERR_DEV_OOR);
        run_cmd(MPI, 32'h1, {32'h9, 32'h2000}, NO_BELL, 64'h0, `VIMC_ERR_VC_OOR);
        run_cmd(MPI, 32'h1, {32'h2, 32'h2000}, NO_BELL, 64'h0, `VIMC_ERR_DEV_UNMAP);
        @(posedge clk);
        {devMapWrite, devMapNumber, devMapValid, devMapSize} <= {1'b1, 4'h1, 1'b1, 2'h3};
        @(posedge clk);
        devMapWrite <= 1'b0;
        run_cmd(MPI, 32'h1, {32'h2, 32'h1}, NO_BELL, 64'h0, `VIMC_ERR_ID_OOR);
        run_cmd(MPI, 32'h1, {32'h2, 32'h2004}, NO_BELL, 64'h0, `VIMC_ERR_ID_OOR);
        run_cmd(MPI, 32'h1, {32'h2, 32'h2003}, {32'h1fff, 32'h0}, 64'h0,
            `VIMC_ERR_DB_OOR);
        run_cmd(MPI, 32'h1, {32'h2, 32'h2000}, NO_BELL, 64'h0, 4'h0);
        run_cmd(MPI, 32'h1, {32'h2, 32'h2001}, {32'h2001, 32'h0}, 64'h0, 4'h0);
        run_cmd(8'h05, 32'h0, 64'h0, 64'h0, 64'h0, `VIMC_ERR_BAD_OP);
        @(posedge clk) errSupport <= 1'b0;
        run_cmd(INV, 32'h0, {32'h8, 32'h0}, 64'h0, 64'h0, `VIMC_ERR_VC_OOR);
        @(posedge clk) errSupport <= 1'b1;
        run_cmd(MPP, 32'h0, {32'h2, 32'h0}, 64'h0, 64'h0, 4'h0);
        check("coreValidMap", 8'h00, coreValidMap);
        run_cmd(INV, 32'h0, {32'h2, 32'h0}, 64'h0, 64'h0, `VIMC_ERR_VC_INVALID);
        @(posedge clk) extVer <= 1'b1;
        run_cmd(MPP, 32'h0, {32'h3, 32'h0}, {1'b1, 15'h0, 32'h5670, 16'h0},
            {12'h0, 36'h2, 16'h0005}, 4'h0);
        check("lastPendingSize", 5'h0e, lastPendingSize);
        check("coreValidMap", 8'h08, coreValidMap);
        // Spurious entry unscheduled, real entry scheduled, real entry unscheduled.
        for (int s = 0; s < 3; s++)
        begin
            @(posedge clk);
            {doorbellQuery, coreScheduled} <= {1'b1, s == 1};
            doorbellEntry <= (s == 0) ? 6'h04 : 6'h05;
            @(posedge clk);
            doorbellQuery <= 1'b0;
            #1;
            check("doorbellFire", s == 2, doorbellFire);
            if (s == 2)
                check("doorbellNumber", 32'h2001, doorbellNumber);
        end
        complete_run();
    end
endmodule // virtual_interrupt_map_commands_tb
